//--- rtl/tmrc_params.svh
// Constants of the timer/counter with shared prescaler.
`ifndef TMRC_PARAMS_SVH
`define TMRC_PARAMS_SVH
`define TMRC_ADR_COUNT 4'h0
`define TMRC_ADR_OPTION 4'h1
`define TMRC_ADR_IRQCTL 4'h2
`define TMRC_ADR_STATUS 4'h3
`define TMRC_ADR_CLEAR 4'h4
`define TMRC_ADR_ENABLE 4'h5
`define TMRC_ADR_CTRL 4'h6
`define TMRC_OPT_SRC 5
`define TMRC_OPT_EDGE 4
`define TMRC_OPT_ASSIGN 3
`define TMRC_IRQ_ENABLE 5
`define TMRC_IRQ_FLAG 2
`define TMRC_OPT_RESET 8'hFF
`define TMRC_INHIBIT_CYCLES 2
`define TMRC_CYCLE_NS 200
`define TMRC_CLK_NS 20
`define TMRC_CYCLE_DIV (`TMRC_CYCLE_NS / `TMRC_CLK_NS)
`endif

//--- rtl/tmrc_pkg.sv
// Types shared by the timer/counter files.
package tmrc_pkg;
    typedef logic [7:0] tmrc_byte_t;
    typedef enum logic [1:0] {
        TMRC_RUN,
        TMRC_HOLD1,
        TMRC_HOLD2
    } tmrc_hold_e;
endpackage : tmrc_pkg

//--- rtl/tmrc_sync.sv
// Two-stage synchroniser with edge detection on the second stage.
`timescale 1ns/10ps
module tmrc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    logic s1, s2, s3;
    logic next_s1, next_s2, next_s3;
    always_comb begin
        next_s1 = pin_i;
        next_s2 = s1;
        next_s3 = s2;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= next_s1;
            s2 <= next_s2;
            s3 <= next_s3;
        end
    end
    assign rise_o = s2 & ~s3;
    assign fall_o = ~s2 & s3;
endmodule : tmrc_sync

//--- rtl/tmrc_prescaler.sv
// Shared 8-bit prescaler; its count is never visible to software.
`timescale 1ns/10ps
module tmrc_prescaler #(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic clear_i,
    input wire logic [2:0] ratio_i,
    output logic tap_o
);
    import tmrc_pkg::*;
    initial begin
        if (WIDTH != 8) $error("prescaler width must be 8");
    end
    logic [WIDTH-1:0] cnt, next_cnt;
    logic [WIDTH-1:0] mask;
    always_comb begin
        mask = WIDTH'((1 << (32'(ratio_i) + 1)) - 1);
        next_cnt = cnt;
        tap_o = 1'b0;
        if (clear_i) begin
            next_cnt = '0;
        end else if (tick_i) begin
            next_cnt = cnt + 1'b1;
            tap_o = ((cnt & mask) == mask);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule : tmrc_prescaler

//--- rtl/tmrc_timer.sv
// Timer/counter top with Wishbone register slave and overflow interrupt.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`include "tmrc_params.svh"
module tmrc_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_count_pin_i,
    input wire logic sleep_i,
    input wire logic watchdog_clear_instr_i,
    output logic watchdog_tick_o,
    output logic irq_o
);
    import tmrc_pkg::*;
    initial begin
        if (`TMRC_CYCLE_DIV < 1) $error("cycle divider below one");
    end

    tmrc_pkg::tmrc_byte_t count_register, next_count_register;
    tmrc_pkg::tmrc_byte_t option_reg, next_option_reg;
    logic overflow_irq_enable, next_overflow_irq_enable;
    logic overflow_flag, next_overflow_flag;
    logic irq_en_mask, next_irq_en_mask;
    tmrc_pkg::tmrc_hold_e hold, next_hold;
    logic [3:0] div, next_div;
    logic [31:0] next_dat;
    logic next_ack, next_irq, next_wdt;
    logic cyc_tick, rise, fall, pin_edge, psc_tick, psc_tap, psc_clr;
    logic src_tick, inc, wr, rd, count_wr;
    logic count_source_select, count_edge_select, prescaler_assign;
    logic [2:0] prescale_ratio_field;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    assign count_source_select = option_reg[`TMRC_OPT_SRC];
    assign count_edge_select = option_reg[`TMRC_OPT_EDGE];
    assign prescaler_assign = option_reg[`TMRC_OPT_ASSIGN];
    assign prescale_ratio_field = option_reg[2:0];

    tmrc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_count_pin_i),
        .rise_o(rise),
        .fall_o(fall)
    );

    // The instruction cycle is a divided enable; sleep freezes it.
    always_comb begin
        next_div = div;
        cyc_tick = 1'b0;
        if (!sleep_i) begin
            if (div == 4'(`TMRC_CYCLE_DIV - 1)) begin
                next_div = 4'h0;
                cyc_tick = 1'b1;
            end else begin
                next_div = div + 4'h1;
            end
        end
    end

    assign pin_edge = count_edge_select ? fall : rise;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign count_wr = wr & hit(wb_adr_i, `TMRC_ADR_COUNT);
    // One prescaler: the source feeding it depends on the assignment.
    assign src_tick = count_source_select ? (pin_edge & ~sleep_i)
                                          : cyc_tick;
    assign psc_tick = prescaler_assign ? cyc_tick : src_tick;
    assign psc_clr = prescaler_assign ? watchdog_clear_instr_i
                                      : count_wr;
    tmrc_prescaler #(.WIDTH(8)) u_psc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(psc_tick),
        .clear_i(psc_clr),
        .ratio_i(prescale_ratio_field),
        .tap_o(psc_tap)
    );
    assign inc = prescaler_assign ? src_tick : psc_tap;

    // Writes to the count inhibit increment for two instruction cycles.
    always_comb begin
        next_hold = hold;
        next_count_register = count_register;
        next_overflow_flag = overflow_flag;
        if (count_wr) begin
            next_count_register = wb_dat_i[7:0];
            next_hold = TMRC_HOLD2;
        end else begin
            case (hold)
                TMRC_HOLD2: if (cyc_tick) next_hold = TMRC_HOLD1;
                TMRC_HOLD1: if (cyc_tick) next_hold = TMRC_RUN;
                TMRC_RUN: begin
                    if (inc) begin
                        next_count_register = count_register + 8'h01;
                        if (count_register == 8'hFF) begin
                            next_overflow_flag = 1'b1;
                        end
                    end
                end
                default: next_hold = TMRC_RUN;
            endcase
        end
        // Set wins over a clear in the same cycle.
        if (!(inc && hold == TMRC_RUN && !count_wr &&
              count_register == 8'hFF)) begin
            if (wr && hit(wb_adr_i, `TMRC_ADR_IRQCTL)) begin
                next_overflow_flag = wb_dat_i[`TMRC_IRQ_FLAG];
            end else if (wr && hit(wb_adr_i, `TMRC_ADR_CLEAR) &&
                         wb_dat_i[0]) begin
                next_overflow_flag = 1'b0;
            end
        end
    end

    always_comb begin
        next_option_reg = option_reg;
        next_overflow_irq_enable = overflow_irq_enable;
        next_irq_en_mask = irq_en_mask;
        if (wr && hit(wb_adr_i, `TMRC_ADR_OPTION)) begin
            next_option_reg = wb_dat_i[7:0];
        end
        if (wr && hit(wb_adr_i, `TMRC_ADR_IRQCTL)) begin
            next_overflow_irq_enable = wb_dat_i[`TMRC_IRQ_ENABLE];
        end
        if (wr && hit(wb_adr_i, `TMRC_ADR_ENABLE)) begin
            next_irq_en_mask = wb_dat_i[0];
        end
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = 32'h00000000;
        if (rd) begin
            case (wb_adr_i)
                `TMRC_ADR_COUNT: next_dat[7:0] = count_register;
                `TMRC_ADR_OPTION: next_dat[7:0] = option_reg;
                `TMRC_ADR_IRQCTL: begin
                    next_dat[`TMRC_IRQ_ENABLE] = overflow_irq_enable;
                    next_dat[`TMRC_IRQ_FLAG] = overflow_flag;
                end
                `TMRC_ADR_STATUS: next_dat[0] = overflow_flag;
                `TMRC_ADR_ENABLE: next_dat[0] = irq_en_mask;
                default: next_dat = 32'h00000000;
            endcase
        end
        next_irq = next_overflow_flag & next_overflow_irq_enable
                 & next_irq_en_mask;
        next_wdt = prescaler_assign ? psc_tap : cyc_tick;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_register <= 8'h00;
            option_reg <= `TMRC_OPT_RESET;
            overflow_irq_enable <= 1'b0;
            overflow_flag <= 1'b0;
            irq_en_mask <= 1'b1;
            hold <= TMRC_RUN;
            div <= 4'h0;
            wb_dat_o <= 32'h00000000;
            wb_ack_o <= 1'b0;
            irq_o <= 1'b0;
            watchdog_tick_o <= 1'b0;
        end else begin
            count_register <= next_count_register;
            option_reg <= next_option_reg;
            overflow_irq_enable <= next_overflow_irq_enable;
            overflow_flag <= next_overflow_flag;
            irq_en_mask <= next_irq_en_mask;
            hold <= next_hold;
            div <= next_div;
            wb_dat_o <= next_dat;
            wb_ack_o <= next_ack;
            irq_o <= next_irq;
            watchdog_tick_o <= next_wdt;
        end
    end

    a_ovf_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        (inc && hold == TMRC_RUN && !count_wr && count_register == 8'hFF)
        |=> overflow_flag && count_register == 8'h00)
        else $error("overflow did not set flag");
    a_irq_gated: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> $past(next_overflow_irq_enable))
        else $error("irq without enable");
    a_write_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        count_wr |=> hold == TMRC_HOLD2)
        else $error("write did not hold counting");
    a_sleep_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        sleep_i |-> !cyc_tick)
        else $error("timer ran in sleep");
    a_timer_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (prescaler_assign && !count_source_select && cyc_tick &&
         hold == TMRC_RUN && !count_wr)
        |=> count_register == $past(count_register) + 8'h01)
        else $error("timer did not step");
    a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_hw_no_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(overflow_flag) |-> $past(wr))
        else $error("hardware cleared flag");
    a_pin_no_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (count_source_select && prescaler_assign && !pin_edge)
        |-> !inc)
        else $error("counter stepped without edge");

    // A timer-side count write must restart the ratio from zero.
    a_psc_clr_timer: assert property (@(posedge clk_i) disable iff (rst_i)
        (!prescaler_assign && count_wr) |=> u_psc.cnt == 8'h00)
        else $error("count write left prescaler running");

    a_psc_clr_wdog: assert property (@(posedge clk_i) disable iff (rst_i)
        (prescaler_assign && watchdog_clear_instr_i) |=> u_psc.cnt == 8'h00)
        else $error("watchdog clear left prescaler running");

    a_wdog_raw_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (!prescaler_assign && !cyc_tick) |=> !watchdog_tick_o)
        else $error("watchdog ticked without a cycle");

    a_wdog_tap_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (prescaler_assign && !psc_tap) |=> !watchdog_tick_o)
        else $error("watchdog ticked without prescaler tap");

    // Without a tap the count must not move when the timer owns the scaler.
    a_psc_gates_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (!prescaler_assign && !count_wr && !psc_tap) |=> $stable(count_register))
        else $error("count stepped without prescaler tap");

    a_edge_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        (count_source_select && !count_edge_select && prescaler_assign &&
         hold == TMRC_RUN && !count_wr && !sleep_i && rise)
        |=> count_register == $past(count_register) + 8'h01)
        else $error("rising edge not counted");

    a_edge_fall: assert property (@(posedge clk_i) disable iff (rst_i)
        (count_source_select && count_edge_select && prescaler_assign &&
         hold == TMRC_RUN && !count_wr && !sleep_i && fall)
        |=> count_register == $past(count_register) + 8'h01)
        else $error("falling edge not counted");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i >= 4'h6) |=> wb_dat_o == 32'h00000000)
        else $error("unmapped index returned data");

    a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("ack not given in next cycle");

    a_option_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == `TMRC_ADR_OPTION)
        |=> option_reg == $past(wb_dat_i[7:0]))
        else $error("option write lost");

    // The flag is sticky: only a bus write may take it down.
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        (overflow_flag && !wr) |=> overflow_flag)
        else $error("flag dropped without a write");

    a_hold_release: assert property (@(posedge clk_i) disable iff (rst_i)
        (hold == TMRC_HOLD1 && cyc_tick && !count_wr) |=> hold == TMRC_RUN)
        else $error("hold did not release");

    a_irq_needs_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> overflow_flag)
        else $error("irq without flag");

    // An edge seen inside must be two clocks old at the pin.
    a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        rise |-> $past(ext_count_pin_i, 2) && !$past(ext_count_pin_i, 3))
        else $error("edge not taken from second stage");

    c_sleep_count: cover property (@(posedge clk_i)
        sleep_i && count_source_select && rise);
    c_wdog_clear: cover property (@(posedge clk_i)
        prescaler_assign && watchdog_clear_instr_i);
    c_overflow: cover property (@(posedge clk_i) $rose(overflow_flag));
    c_irq: cover property (@(posedge clk_i) $rose(irq_o));
    c_write: cover property (@(posedge clk_i) count_wr);
endmodule : tmrc_timer

//--- testbench/tmrc_ext_source.sv
// Model of the external source that drives the counter input pin.
`timescale 1ns/10ps
module tmrc_ext_source (
    input wire logic clk_i,
    output logic pin_o
);
    initial begin
        pin_o = 1'b0;
    end
    // Each level is held three clocks, because a shorter one could slip
    // between the two flops of the input stage.
    task automatic set_level(input logic lvl);
        pin_o <= lvl;
        repeat (3) @(posedge clk_i);
    endtask : set_level
    // The pin rests low between bursts, as a real source would.
    task automatic pulses(input int n);
        repeat (n) begin
            set_level(1'b1);
            set_level(1'b0);
        end
    endtask : pulses
endmodule : tmrc_ext_source

//--- testbench/timer0_counter_prescaler_tb.sv
// Self-checking bench for the timer/counter with shared prescaler.
`timescale 1ns/10ps
module timer0_counter_prescaler_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic sleep = 1'b0;
    logic pin;
    logic [31:0] dat_r;
    logic ack;
    logic irq;
    logic [7:0] rnd;
    logic [3:0] sel = 4'hF;
    logic wdclr = 1'b0;
    logic wdt;
    int nw;
    logic [31:0] exp_q[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;

    tmrc_ext_source src_u (.clk_i(clk_i), .pin_o(pin));

    tmrc_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .ext_count_pin_i(pin), .sleep_i(sleep),
        .watchdog_clear_instr_i(wdclr), .watchdog_tick_o(wdt),
        .irq_o(irq));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // A read notes its expected byte before the cycle starts.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        if (!w) exp_q.push_back({24'h0, d});
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        cyc <= 1'b0;
    endtask : bus

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // Read data is only taken at the edge that samples ack high.
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            check(dat_r, exp_q.pop_front());
        end
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'hF83AC150));
        tick(4);
        rst_i <= 1'b0;
        bus(0, 4'h1, 8'hFF);
        bus(0, 4'h0, 8'h00);
        bus(0, 4'h2, 8'h00);
        bus(0, 4'h7, 8'h00);
        sel <= 4'hE;
        bus(1, 4'h1, 8'h00);
        sel <= 4'hF;
        bus(0, 4'h1, 8'hFF);
        $display("end of reset test");
        rnd = 8'($urandom());
        bus(1, 4'h1, 8'h08);
        bus(1, 4'h0, rnd);
        bus(0, 4'h0, rnd);
        bus(1, 4'h2, 8'h20);
        bus(1, 4'h0, 8'hFE);
        tick(60);
        bus(0, 4'h3, 8'h01);
        check(32'(irq), 32'h1);
        bus(0, 4'h2, 8'h24);
        bus(1, 4'h2, 8'h04);
        tick(3);
        check(32'(irq), 32'h0);
        bus(0, 4'h3, 8'h01);
        bus(1, 4'h4, 8'h01);
        bus(0, 4'h3, 8'h00);
        $display("end of timer and overflow test");
        // A trailing high level tells the two edge choices apart.
        for (int e = 0; e < 2; e++) begin
            bus(1, 4'h1, 8'h28 | 8'(e << 4));
            bus(1, 4'h0, 8'h00);
            tick(30);
            src_u.pulses(4);
            src_u.set_level(1'b1);
            tick(5);
            bus(0, 4'h0, 8'(5 - e));
            src_u.set_level(1'b0);
        end
        $display("end of edge test");
        for (int r = 0; r < 3; r++) begin
            bus(1, 4'h1, 8'h20 | 8'(r));
            bus(1, 4'h0, 8'h00);
            tick(30);
            src_u.pulses(3 << (r + 1));
            tick(5);
            bus(0, 4'h0, 8'h03);
        end
        $display("end of prescaler test");
        bus(1, 4'h1, 8'h28);
        bus(1, 4'h0, 8'h00);
        // Sleep starts after the write hold is over, so only sleep stops it.
        tick(30);
        sleep <= 1'b1;
        src_u.pulses(4);
        bus(0, 4'h0, 8'h00);
        sleep <= 1'b0;
        $display("end of sleep test");
        bus(1, 4'h1, 8'h08);
        @(posedge clk_i);
        wdclr <= 1'b1;
        @(posedge clk_i);
        wdclr <= 1'b0;
        nw = 0;
        repeat (205) begin
            @(posedge clk_i);
            if (wdt === 1'b1) nw++;
        end
        check(32'(nw), 32'hA);
        $display("end of watchdog test");
        tick(3);
        wrap_up();
    end
endmodule : timer0_counter_prescaler_tb
